// [common/kwr_pkg.sv]
// How it works
// - config bits 5:4 pick release policy
// - option 00 gives half second pulse
// - option 00 blocks retrigger during pulse
// - option 01 holds until non-make code
// - option 01 suppresses new events meanwhile
// - option 10 holds until break code
// - option 10 suppresses new events meanwhile
// - releasing event leaves sticky status set
// - single-byte code valid without parity error
// - multi-byte code needs make byte one first
// - config bits 3:2 pick scan code type
// - type 00 matches break byte one
// - types 01/10 then match break byte two
// - second byte must be valid and match
// - mismatch, parity or timeout restarts decode
// - type 11 matches three break bytes
// - programmed 00h matches any byte
// - 125 us stuck clock line is timeout
package kwr_pkg;
	// register map, byte offsets on the 8-bit register port
	localparam logic [7:0] KWR_OFS_MAKE1 = 8'h5f;
	localparam logic [7:0] KWR_OFS_MAKE2 = 8'h60;
	localparam logic [7:0] KWR_OFS_BRK1 = 8'h61;
	localparam logic [7:0] KWR_OFS_BRK2 = 8'h62;
	localparam logic [7:0] KWR_OFS_BRK3 = 8'h63;
	localparam logic [7:0] KWR_OFS_CFG = 8'h64;
	localparam logic [7:0] KWR_OFS_STAT = 8'h65;
	localparam logic [7:0] KWR_RESET_BYTE = 8'h00;
	localparam logic [7:0] KWR_DONT_CARE = 8'h00;
	// config and status fields
	localparam int KWR_TYPE_LO = 2;
	localparam int KWR_REL_LO = 4;
	localparam int KWR_STAT_ACTIVE = 0;
	localparam int KWR_STAT_STICKY = 1;
	localparam logic [1:0] KWR_REL_PULSE = 2'h0;
	localparam logic [1:0] KWR_REL_NONMAKE = 2'h1;
	localparam logic [1:0] KWR_REL_BREAK = 2'h2;
	localparam logic [1:0] KWR_TYPE_ONE = 2'h0;
	localparam logic [1:0] KWR_TYPE_THREE = 2'h3;
	// timing
	localparam int KWR_CLK_NS = 100;
	localparam int KWR_TIMEOUT_US = 125;
	localparam int KWR_TIMEOUT_CYCLES = (KWR_TIMEOUT_US * 1000) / KWR_CLK_NS;
	localparam int KWR_PULSE_MS = 500;
	localparam int KWR_PULSE_CYCLES = (KWR_PULSE_MS * 1000000) / KWR_CLK_NS;
	typedef struct packed {
		logic [7:0] data;
		logic parityErr;
	} kwr_byte_s;
	typedef enum logic [1:0] {
		W_IDLE = 2'b00,
		W_PULSE = 2'b01,
		W_HOLD_NM = 2'b10,
		W_HOLD_BRK = 2'b11
	} kwr_wake_e;
	typedef enum logic [1:0] {
		B_FIRST = 2'b00,
		B_SECOND = 2'b01,
		B_THIRD = 2'b10
	} kwr_brk_e;
	// a programmed zero is a wildcard
	function automatic logic kwr_match(input logic [7:0] b, input logic [7:0] p);
		return (p == KWR_DONT_CARE) || (b == p);
	endfunction
endpackage

// [verilog/kwr_link_rx.sv]
`timescale 1ns/1ps
`default_nettype none
module kwr_link_rx (
	input wire logic linkClock,
	input wire logic sys_rst,
	input wire logic rxStrobe,
	input wire kwr_pkg::kwr_byte_s rxByte,
	input wire logic ackToggle,
	output logic reqToggle,
	output kwr_pkg::kwr_byte_s heldByte
);
	import kwr_pkg::*;
	logic rstMeta, rstLink, ackMeta, ackSync, busy;
	// reset brought into the link domain
	always_ff @(posedge linkClock) begin
		rstMeta <= sys_rst;
		rstLink <= rstMeta;
	end
	// acknowledge toggle from the system side
	always_ff @(posedge linkClock) begin
		ackMeta <= ackToggle;
		ackSync <= ackMeta;
	end
	// held word must stay still until acknowledged
	assign busy = reqToggle != ackSync;
	// a byte arriving while busy is dropped; bytes are far slower than the crossing
	always_ff @(posedge linkClock) begin
		if (rstLink) begin
			reqToggle <= 1'b0;
			heldByte <= '0;
		end else if (rxStrobe && !busy) begin
			heldByte <= rxByte;
			reqToggle <= ~reqToggle;
		end
	end
endmodule
`default_nettype wire

// [verilog/kwr_timeout.sv]
`timescale 1ns/1ps
`default_nettype none
module kwr_timeout #(
	parameter int CYCLES = kwr_pkg::KWR_TIMEOUT_CYCLES
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic keyboardClockLine,
	input wire logic byteDone,
	output logic timeoutPulse
);
	import kwr_pkg::*;
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	logic lineMeta, lineSync, lineLast, armed, edgeSeen, expire;
	logic [CW-1:0] cnt;
	// pin crosses two flops first
	always_ff @(posedge clock) begin
		lineMeta <= keyboardClockLine;
		lineSync <= lineMeta;
		lineLast <= lineSync;
	end
	assign edgeSeen = lineSync != lineLast;
	assign expire = armed && !edgeSeen && (cnt == LAST);
	// a byte starts at the first falling clock edge
	always_ff @(posedge clock) begin
		if (sys_rst)
			armed <= 1'b0;
		else if (byteDone || expire)
			armed <= 1'b0;
		else if (lineLast && !lineSync)
			armed <= 1'b1;
	end
	// level held too long while in a byte
	always_ff @(posedge clock) begin
		if (sys_rst || !armed || edgeSeen)
			cnt <= '0;
		else if (cnt != LAST)
			cnt <= cnt + 1'b1;
	end
	always_ff @(posedge clock) begin
		if (sys_rst)
			timeoutPulse <= 1'b0;
		else
			timeoutPulse <= expire;
	end
	a_timeout_fires: assert property (@(posedge clock) disable iff (sys_rst)
		armed && !edgeSeen && cnt == LAST |=> timeoutPulse ##1 !timeoutPulse)
		else $error("timeout pulse missing after stuck clock line");
endmodule
`default_nettype wire

// [verilog/kwr_wake_release.sv]
`timescale 1ns/1ps
`default_nettype none
module kwr_wake_release #(
	parameter int unsigned PULSE_CYCLES = kwr_pkg::KWR_PULSE_CYCLES
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic linkClock,
	input wire logic rxStrobe,
	input wire kwr_pkg::kwr_byte_s rxByte,
	input wire logic keyboardClockLine,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	output logic keyWakeEvent_n,
	output logic wakeStatus
);
	import kwr_pkg::*;
	localparam int PW = $clog2(PULSE_CYCLES + 1);
	localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_CYCLES - 1);

	// registers
	logic [7:0] make1_reg, make2_reg, brk1_reg, brk2_reg, brk3_reg, cfg_reg;
	logic [1:0] relOpt, scanType;
	logic multiMake, clearSticky;
	logic [7:0] statusWord;

	// crossing from the link domain
	logic reqToggle, reqMeta, reqSync, reqSeen, ackToggle_reg;
	kwr_byte_s heldByte, capt_reg;
	logic byteEvent_reg;

	// decode
	logic timeoutPulse, byteValid, byteBad;
	logic firstSeen_reg, codeDone, codeIsMake, makeHit;
	kwr_brk_e brk_reg, brk_next;
	logic [7:0] brkProg;
	logic brkLast, brkMatch, brkHit;

	// wake state
	kwr_wake_e wake_reg, wake_next;
	logic [PW-1:0] pulseCnt_reg;

	// link-side capture with toggle handshake
	kwr_link_rx linkRx (
		.linkClock(linkClock),
		.sys_rst(sys_rst),
		.rxStrobe(rxStrobe),
		.rxByte(rxByte),
		.ackToggle(ackToggle_reg),
		.reqToggle(reqToggle),
		.heldByte(heldByte)
	);

	// stuck keyboard clock detector
	kwr_timeout #(
		.CYCLES(KWR_TIMEOUT_CYCLES)
	) timeout (
		.clock(clock),
		.sys_rst(sys_rst),
		.keyboardClockLine(keyboardClockLine),
		.byteDone(byteEvent_reg),
		.timeoutPulse(timeoutPulse)
	);

	// request toggle passes two flops; held word is stable by then
	always_ff @(posedge clock) begin
		reqMeta <= reqToggle;
		reqSync <= reqMeta;
	end

	// take the word once, then acknowledge
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reqSeen <= 1'b0;
			ackToggle_reg <= 1'b0;
			byteEvent_reg <= 1'b0;
			capt_reg <= '0;
		end else begin
			byteEvent_reg <= reqSync != reqSeen;
			if (reqSync != reqSeen) begin
				capt_reg <= heldByte;
				reqSeen <= reqSync;
				ackToggle_reg <= reqSync;
			end
		end
	end

	// config fields
	assign relOpt = cfg_reg[KWR_REL_LO +: 2];
	assign scanType = cfg_reg[KWR_TYPE_LO +: 2];
	assign multiMake = scanType[0];

	// a byte with a parity error is never a valid code byte
	assign byteValid = byteEvent_reg && !capt_reg.parityErr;
	assign byteBad = timeoutPulse || (byteEvent_reg && capt_reg.parityErr);

	// make code assembly: multi-byte codes must open with make byte one
	always_ff @(posedge clock) begin
		if (sys_rst || byteBad || !multiMake)
			firstSeen_reg <= 1'b0;
		else if (byteValid && !firstSeen_reg)
			firstSeen_reg <= kwr_match(capt_reg.data, make1_reg);
		else if (byteValid)
			firstSeen_reg <= 1'b0;
	end

	// a complete valid scan code and whether it is the make code
	always_comb begin
		codeDone = byteValid && !timeoutPulse && (!multiMake || firstSeen_reg);
		if (multiMake)
			codeIsMake = kwr_match(capt_reg.data, make2_reg);
		else
			codeIsMake = kwr_match(capt_reg.data, make1_reg);
		makeHit = codeDone && codeIsMake;
	end

	// break stage compare value and sequence length
	always_comb begin
		case (brk_reg)
			B_FIRST: brkProg = brk1_reg;
			B_SECOND: brkProg = brk2_reg;
			B_THIRD: brkProg = brk3_reg;
			default: brkProg = brk1_reg;
		endcase
		case (scanType)
			KWR_TYPE_ONE: brkLast = brk_reg == B_FIRST;
			KWR_TYPE_THREE: brkLast = brk_reg == B_THIRD;
			default: brkLast = brk_reg == B_SECOND;
		endcase
		brkMatch = kwr_match(capt_reg.data, brkProg);
		brkHit = (wake_reg == W_HOLD_BRK) && byteValid && !timeoutPulse && brkMatch && brkLast;
	end

	// break sequence state; any fault starts over at the first byte
	always_comb begin
		brk_next = brk_reg;
		if (wake_reg != W_HOLD_BRK || byteBad)
			brk_next = B_FIRST;
		else if (byteValid) begin
			if (brkMatch && !brkLast)
				brk_next = kwr_brk_e'(brk_reg + 2'h1);
			else
				brk_next = B_FIRST;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			brk_reg <= B_FIRST;
		else
			brk_reg <= brk_next;
	end

	// wake event release policies
	always_comb begin
		wake_next = wake_reg;
		case (wake_reg)
			W_IDLE: begin
				if (makeHit) begin
					case (relOpt)
						KWR_REL_PULSE: wake_next = W_PULSE;
						KWR_REL_NONMAKE: wake_next = W_HOLD_NM;
						KWR_REL_BREAK: wake_next = W_HOLD_BRK;
						default: wake_next = W_IDLE;
					endcase
				end
			end
			W_PULSE: begin
				// make codes are ignored until the pulse ends
				if (pulseCnt_reg == PULSE_LAST)
					wake_next = W_IDLE;
			end
			W_HOLD_NM: begin
				if (codeDone && !codeIsMake)
					wake_next = W_IDLE;
			end
			W_HOLD_BRK: begin
				if (brkHit)
					wake_next = W_IDLE;
			end
			default: wake_next = W_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			wake_reg <= W_IDLE;
		else
			wake_reg <= wake_next;
	end

	// pulse width counted on the system clock
	always_ff @(posedge clock) begin
		if (sys_rst || wake_reg != W_PULSE)
			pulseCnt_reg <= '0;
		else
			pulseCnt_reg <= pulseCnt_reg + 1'b1;
	end

	// active-low event follows the state register
	always_ff @(posedge clock) begin
		if (sys_rst)
			keyWakeEvent_n <= 1'b1;
		else
			keyWakeEvent_n <= wake_next == W_IDLE;
	end

	// sticky status: release never clears it, a set beats a software clear
	assign clearSticky = regWrite && regAddr == KWR_OFS_STAT && regWdata[KWR_STAT_STICKY];
	always_ff @(posedge clock) begin
		if (sys_rst)
			wakeStatus <= 1'b0;
		else if (wake_reg == W_IDLE && wake_next != W_IDLE)
			wakeStatus <= 1'b1;
		else if (clearSticky)
			wakeStatus <= 1'b0;
	end

	// register writes
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			make1_reg <= KWR_RESET_BYTE;
			make2_reg <= KWR_RESET_BYTE;
			brk1_reg <= KWR_RESET_BYTE;
			brk2_reg <= KWR_RESET_BYTE;
			brk3_reg <= KWR_RESET_BYTE;
			cfg_reg <= KWR_RESET_BYTE;
		end else if (regWrite) begin
			case (regAddr)
				KWR_OFS_MAKE1: make1_reg <= regWdata;
				KWR_OFS_MAKE2: make2_reg <= regWdata;
				KWR_OFS_BRK1: brk1_reg <= regWdata;
				KWR_OFS_BRK2: brk2_reg <= regWdata;
				KWR_OFS_BRK3: brk3_reg <= regWdata;
				KWR_OFS_CFG: cfg_reg <= regWdata;
				default: ;
			endcase
		end
	end

	// status word shows live event and sticky bit
	always_comb begin
		statusWord = '0;
		statusWord[KWR_STAT_ACTIVE] = !keyWakeEvent_n;
		statusWord[KWR_STAT_STICKY] = wakeStatus;
	end

	// read data stands one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clock) begin
		if (sys_rst || !regRead)
			regRdata <= '0;
		else begin
			case (regAddr)
				KWR_OFS_MAKE1: regRdata <= make1_reg;
				KWR_OFS_MAKE2: regRdata <= make2_reg;
				KWR_OFS_BRK1: regRdata <= brk1_reg;
				KWR_OFS_BRK2: regRdata <= brk2_reg;
				KWR_OFS_BRK3: regRdata <= brk3_reg;
				KWR_OFS_CFG: regRdata <= cfg_reg;
				KWR_OFS_STAT: regRdata <= statusWord;
				default: regRdata <= '0;
			endcase
		end
	end

	a_reserved_no_wake: assert property (@(posedge clock) disable iff (sys_rst)
		wake_reg == W_IDLE && relOpt == 2'h3 |=> keyWakeEvent_n)
		else $error("reserved release option raised an event");

	a_option_select: assert property (@(posedge clock) disable iff (sys_rst)
		wake_reg == W_IDLE && makeHit && relOpt == KWR_REL_NONMAKE |=> wake_reg == W_HOLD_NM && !keyWakeEvent_n)
		else $error("option 01 did not hold the event");

	a_pulse_ends: assert property (@(posedge clock) disable iff (sys_rst)
		wake_reg == W_PULSE && pulseCnt_reg == PULSE_LAST |=> keyWakeEvent_n && wake_reg == W_IDLE)
		else $error("fixed pulse did not end on time");

	a_pulse_starts: assert property (@(posedge clock) disable iff (sys_rst)
		wake_reg == W_IDLE && makeHit && relOpt == KWR_REL_PULSE |=> !keyWakeEvent_n && pulseCnt_reg == '0)
		else $error("fixed pulse did not start");

	a_pulse_no_retrig: assert property (@(posedge clock) disable iff (sys_rst)
		wake_reg == W_PULSE && pulseCnt_reg != PULSE_LAST |=> wake_reg == W_PULSE && $changed(pulseCnt_reg))
		else $error("pulse restarted or stalled");

	a_nm_release: assert property (@(posedge clock) disable iff (sys_rst)
		wake_reg == W_HOLD_NM && codeDone && !codeIsMake |=> keyWakeEvent_n)
		else $error("non-make code did not release the event");

	a_nm_suppress: assert property (@(posedge clock) disable iff (sys_rst)
		wake_reg == W_HOLD_NM && !(codeDone && !codeIsMake) |=> wake_reg == W_HOLD_NM && !keyWakeEvent_n)
		else $error("event left hold without non-make code");

	a_brk_release: assert property (@(posedge clock) disable iff (sys_rst)
		brkHit |=> keyWakeEvent_n && brk_reg == B_FIRST)
		else $error("break code did not release the event");

	a_brk_suppress: assert property (@(posedge clock) disable iff (sys_rst)
		wake_reg == W_HOLD_BRK && !brkHit |=> wake_reg == W_HOLD_BRK)
		else $error("event left break hold without break code");

	a_sticky_kept: assert property (@(posedge clock) disable iff (sys_rst)
		wakeStatus && !clearSticky |=> wakeStatus)
		else $error("sticky status lost without clear");

	a_parity_invalid: assert property (@(posedge clock) disable iff (sys_rst)
		byteEvent_reg && capt_reg.parityErr |-> !codeDone && !brkHit)
		else $error("parity error byte used as code");

	a_brk_restart: assert property (@(posedge clock) disable iff (sys_rst)
		byteBad |=> brk_reg == B_FIRST)
		else $error("break decode not restarted after fault");

	a_brk_two_step: assert property (@(posedge clock) disable iff (sys_rst)
		wake_reg == W_HOLD_BRK && brk_reg == B_FIRST && byteValid && !timeoutPulse && brkMatch
		&& scanType != KWR_TYPE_ONE |=> brk_reg == B_SECOND && !keyWakeEvent_n)
		else $error("first break byte did not advance decode");

	a_sticky_set: assert property (@(posedge clock) disable iff (sys_rst)
		wake_reg == W_IDLE && wake_next != W_IDLE |=> wakeStatus)
		else $error("sticky status not set by a new event");

	a_brk_one_byte: assert property (@(posedge clock) disable iff (sys_rst)
		wake_reg == W_HOLD_BRK && brk_reg == B_FIRST && scanType == KWR_TYPE_ONE && byteValid
		&& !timeoutPulse && kwr_match(capt_reg.data, brk1_reg) |=> keyWakeEvent_n && wake_reg == W_IDLE)
		else $error("one-byte break did not release the event");

	a_brk_three_step: assert property (@(posedge clock) disable iff (sys_rst)
		wake_reg == W_HOLD_BRK && brk_reg == B_SECOND && scanType == KWR_TYPE_THREE && byteValid
		&& !timeoutPulse && brkMatch |=> brk_reg == B_THIRD && !keyWakeEvent_n)
		else $error("second break byte did not advance to the third");

	a_brk_second_miss: assert property (@(posedge clock) disable iff (sys_rst)
		wake_reg == W_HOLD_BRK && brk_reg == B_SECOND && byteEvent_reg && !brkMatch
		|=> brk_reg == B_FIRST && !keyWakeEvent_n)
		else $error("unmatched second break byte released the event");

	a_make_needs_first: assert property (@(posedge clock) disable iff (sys_rst)
		multiMake && wake_reg == W_IDLE && byteValid && !firstSeen_reg |=> keyWakeEvent_n)
		else $error("multi-byte make accepted without make byte one");

	a_timeout_restart: assert property (@(posedge clock) disable iff (sys_rst)
		timeoutPulse |=> brk_reg == B_FIRST && !firstSeen_reg)
		else $error("timeout did not restart the decode");
endmodule
`default_nettype wire

// [bench/kwr_kbd_model.sv]
`timescale 1ns/1ps
`default_nettype none
module kwr_kbd_model (
	input wire logic linkClock,
	output logic rxStrobe,
	output kwr_pkg::kwr_byte_s rxByte,
	output logic keyboardClockLine
);
	import kwr_pkg::*;
	// idle: clock line sits at its pull-up level
	initial begin
		rxStrobe = 1'b0;
		rxByte = '0;
		keyboardClockLine = 1'b1;
	end
	// one byte; a stuck line holds low 130 us, just past the 125 us timeout, before the byte lands
	task automatic send(input logic [7:0] d, input logic perr, input logic stuck);
		keyboardClockLine = 1'b0;
		#(stuck ? 130000 : 1000);
		keyboardClockLine = 1'b1;
		@(posedge linkClock);
		rxStrobe <= 1'b1;
		rxByte <= {d, perr};
		@(posedge linkClock);
		rxStrobe <= 1'b0;
		rxByte <= ~{d, perr}; // stale bus must not look like the last byte
	endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import kwr_pkg::*;
	localparam int PULSE_P = 200; // short pulse keeps the run brief
	logic clock = 1'b0;
	logic linkClock = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	wire logic rxStrobe;
	wire kwr_byte_s rxByte;
	wire logic keyboardClockLine;
	wire logic [7:0] regRdata;
	wire logic keyWakeEvent_n;
	wire logic wakeStatus;
	int errorCnt = 0;
	int testsRun = 0;
	// reference model: wake state, break step, make step, pulse budget
	int st = 0;
	int bStep = 0;
	int mkStep = 0;
	int pulseLeft = 0;
	bit sticky = 0;
	logic [7:0] rg [0:255];
	logic [31:0] seed = 32'h00006c87;
	logic [31:0] r;

	always #50 clock = ~clock;
	// link clock free of any phase relation to the system clock
	initial begin
		#1.7;
		forever #3 linkClock = ~linkClock;
	end

	kwr_wake_release #(.PULSE_CYCLES(PULSE_P)) dut (.clock(clock), .sys_rst(sys_rst), .linkClock(linkClock),
		.rxStrobe(rxStrobe), .rxByte(rxByte), .keyboardClockLine(keyboardClockLine), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.keyWakeEvent_n(keyWakeEvent_n), .wakeStatus(wakeStatus));
	kwr_kbd_model kbd (.linkClock(linkClock), .rxStrobe(rxStrobe), .rxByte(rxByte),
		.keyboardClockLine(keyboardClockLine));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// zero in a pattern register matches anything
	function automatic bit mt(input logic [7:0] b, input logic [7:0] p);
		return (p == 8'h00) || (b == p);
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		testsRun++;
		if (got !== exp) begin
			errorCnt++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", testsRun, errorCnt);
		if (errorCnt == 0 && testsRun > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
		if (a >= 8'h5f && a <= 8'h64) rg[a] = d;
		if (a == 8'h65 && d[1]) sticky = 0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic [7:0] e;
		e = (a >= 8'h5f && a <= 8'h64) ? rg[a] : 8'h00;
		if (a == 8'h65) e = {6'h00, sticky, st != 0};
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		@(negedge clock);
		chk(regRdata, e, "read");
	endtask
	task automatic age(input int n);
		repeat (n) @(posedge clock);
		pulseLeft -= n;
		if (st == 1 && pulseLeft <= 0) st = 0;
	endtask
	task automatic look();
		@(negedge clock);
		chk({7'h00, keyWakeEvent_n}, {7'h00, st == 0}, "wake event");
		chk({7'h00, wakeStatus}, {7'h00, sticky}, "wake status");
	endtask
	// model reaction to one received byte; s marks a timed-out frame
	task automatic mdl(input logic [7:0] d, input bit p, input bit s);
		logic [1:0] ty;
		logic [1:0] op;
		bit hit;
		ty = rg[8'h64][3:2];
		op = rg[8'h64][5:4];
		hit = 0;
		if (s || p) begin
			bStep = 0;
			mkStep = 0;
		end
		if (p) begin
		end else if (st == 0) begin
			if (!ty[0]) hit = mt(d, rg[8'h5f]);
			else if (mkStep == 0) mkStep = mt(d, rg[8'h5f]);
			else begin
				hit = mt(d, rg[8'h60]);
				mkStep = 0;
			end
			if (hit && op != 2'h3) begin
				st = op + 1;
				sticky = 1;
				pulseLeft = PULSE_P - 25;
				bStep = 0;
			end
		end else if (st == 2) begin
			if (d != rg[8'h5f]) st = 0;
		end else if (st == 3) begin
			case (bStep)
				0: if (mt(d, rg[8'h61])) bStep = 1;
				1: bStep = mt(d, rg[8'h62]) ? 2 : 0;
				default: bStep = mt(d, rg[8'h63]) ? 3 : 0;
			endcase
			if (bStep == 1 && ty == 2'h0 || bStep == 2 && ty != 2'h3 || bStep == 3) begin
				st = 0;
				bStep = 0;
			end
		end
	endtask
	task automatic kb(input logic [7:0] d, input bit p, input bit s);
		kbd.send(d, p, s);
		age(25);
		mdl(d, p, s);
		look();
	endtask
	task automatic cfgw(input logic [1:0] opt, input logic [1:0] ty);
		r = xs();
		wr(8'h64, {r[7:6], opt, ty, r[1:0]});
		rd(8'h64);
	endtask
	// clear the sticky bit and confirm it drops
	task automatic done(input string name);
		wr(8'h65, 8'h02);
		age(2);
		look();
		$display("test %s done", name);
	endtask

	initial begin
		#5000000;
		errorCnt++;
		$display("CHECK FAILED at %0t: run did not finish", $time);
		conclude();
	end

	initial begin
		foreach (rg[i]) rg[i] = 8'h00;
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clock);
		for (int a = 8'h5f; a <= 8'h65; a++) rd(8'(a));
		rd(8'h70);
		$display("test registers done");
		// fixed pulse
		wr(8'h5f, 8'h5a);
		cfgw(2'h0, 2'h0);
		kb(8'h5a, 0, 0);
		kb(8'h5a, 0, 0);
		age(130);
		look();
		age(20);
		look();
		rd(8'h65);
		done("pulse");
		// release on a differing code
		cfgw(2'h1, 2'h0);
		kb(8'h5a, 0, 0);
		kb(8'h5a, 0, 0);
		r = xs();
		if (r[7:0] == 8'h5a) r[7:0] = 8'h5b;
		kb(r[7:0], 1, 0);
		kb(r[7:0], 0, 0);
		done("non-make");
		// one-byte break
		wr(8'h61, 8'hda);
		cfgw(2'h2, 2'h0);
		kb(8'h5a, 0, 0);
		kb(8'h5a, 0, 0);
		kb(8'hda, 1, 0);
		kb(8'hda, 0, 0);
		done("break one");
		// two-byte break, two-byte make with wildcard second byte
		wr(8'h61, 8'he0);
		wr(8'h62, 8'hb7);
		cfgw(2'h2, 2'h1);
		kb(8'h5a, 0, 1);
		kb(8'h11, 0, 0);
		kb(8'he0, 0, 0);
		kb(8'h11, 0, 0);
		kb(8'hb7, 0, 0);
		kb(8'he0, 0, 0);
		kb(8'hb7, 0, 1);
		kb(8'he0, 0, 0);
		kb(8'hb7, 1, 0);
		kb(8'he0, 0, 0);
		kb(8'hb7, 0, 0);
		done("break two");
		// three-byte break, last byte any
		wr(8'h60, 8'h37);
		wr(8'h62, 8'hf0);
		wr(8'h63, 8'h00);
		cfgw(2'h2, 2'h3);
		kb(8'h5a, 0, 1);
		kb(8'h37, 0, 0);
		kb(8'he0, 0, 0);
		kb(8'hf0, 0, 0);
		r = xs();
		kb(r[7:0], 0, 0);
		done("break three");
		// two-byte break after a one-byte make
		cfgw(2'h2, 2'h2);
		kb(8'h5a, 0, 0);
		kb(8'he0, 0, 0);
		kb(8'hf0, 0, 0);
		done("break two single make");
		// reserved release option gives no event
		cfgw(2'h3, 2'h0);
		kb(8'h5a, 0, 1);
		done("reserved");
		conclude();
	end
endmodule
`default_nettype wire
